// >>> cmode_pkg.sv
package cmode_pkg;
  // Base after any reset, handler and save-area offsets
  localparam logic [31:0] CM_BASE_RESET = 32'h0003_0000;
  localparam logic [31:0] CM_HANDLER_OFS = 32'h0000_8000;
  localparam logic [31:0] CM_SAVE_OFS = 32'h0000_FE00;
  localparam logic [31:0] CM_SAVE_LAST_OFS = 32'h0000_FFFF;
  localparam logic [31:0] CM_RESTART_OFS = 32'h0000_FEC8;
  localparam logic [31:0] CM_BASE_IMG_OFS = 32'h0000_FEF8;
  localparam logic [31:0] CM_MEM_SIZE_DEF = 32'h0001_0000;
  localparam logic [31:0] CM_MEM_SIZE_MIN = 32'h0000_8000;
  // Revision code value is arbitrary; only the relocation bit is fixed
  localparam logic [31:0] CM_REV_CODE = 32'h0000_0064;
  localparam int CM_RELOC_BIT = 17;
  localparam logic [31:0] CM_REV_ID = CM_REV_CODE | (32'h0000_0001 << CM_RELOC_BIT);
  localparam logic [15:0] CM_CS_SEL_DEF = 16'h3000;
  localparam int CM_SEL_SHIFT = 4;
  localparam logic [31:0] CM_REAL_MAX = 32'h0010_FFEF;
  localparam int CM_CORE_WORDS_DEF = 8;
  localparam int CM_WORD_SHIFT = 3;
  localparam int CM_IO_BYTE_POS = 0;
  localparam int CM_HALT_BYTE_POS = 8;

  typedef enum logic [1:0] {CM_IDLE, CM_SAVE, CM_RUN, CM_RESTORE} cmode_phase_type;

  // Real-mode segment base: selector shifted into a 20-bit address
  function automatic logic [31:0] cmode_seg_base(input logic [15:0] sel);
    cmode_seg_base = 32'(sel) << CM_SEL_SHIFT;
  endfunction : cmode_seg_base
endpackage : cmode_pkg

// >>> cmode_if.sv
interface cmode_seq_if;
  logic start_save;
  logic start_restore;
  logic done;
  logic [31:0] base;
  logic [31:0] restored_base;
  modport ctrl(output start_save, output start_restore, output base, input done, input restored_base);
  modport seq(input start_save, input start_restore, input base, output done, output restored_base);
endinterface : cmode_seq_if

interface cmode_agu_if;
  logic [15:0] sel;
  logic [31:0] off;
  logic ovr;
  logic [31:0] addr;
  modport core(output sel, output off, output ovr, input addr);
  modport agu(input sel, input off, input ovr, output addr);
endinterface : cmode_agu_if

// >>> cmode_agu.sv
module cmode_agu
  import cmode_pkg::*;
(
  input wire logic clock_in,
  input wire logic rstn_in,
  cmode_agu_if.agu port
);
  typedef struct packed {
    logic [31:0] addr;
  } cmode_agu_state_type;

  cmode_agu_state_type s;
  cmode_agu_state_type next_s;

  always_comb begin
    next_s = s;
    // 16-bit offsets unless a 32-bit override is present
    if (port.ovr) begin
      next_s.addr = cmode_seg_base(port.sel) + port.off;
    end else begin
      next_s.addr = cmode_seg_base(port.sel) + {16'h0000, port.off[15:0]};
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign port.addr = s.addr;

  real_max_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !port.ovr |=> (port.addr <= CM_REAL_MAX) && (port.addr == cmode_seg_base($past(port.sel)) + 32'($past(port.off[15:0]))))
    else $error("real-mode address wrong or above limit");
endmodule : cmode_agu

// >>> cmode_xfer.sv
module cmode_xfer
  import cmode_pkg::*;
#(
  parameter int CORE_WORDS = CM_CORE_WORDS_DEF,
  localparam int IW = $clog2(CORE_WORDS + 2)
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  cmode_seq_if.seq ctl,
  output logic [IW-1:0] state_idx_out,
  input wire logic [63:0] state_word_in,
  input wire logic [7:0] io_restart_in,
  input wire logic [7:0] halt_restart_in,
  output logic mem_req_out,
  output logic mem_we_out,
  output logic [31:0] mem_addr_out,
  output logic [63:0] mem_wdata_out,
  input wire logic mem_ack_in,
  input wire logic [63:0] mem_rdata_in,
  output logic restore_valid_out,
  output logic [IW-1:0] restore_idx_out,
  output logic [63:0] restore_word_out,
  output logic [7:0] io_restart_out,
  output logic [7:0] halt_restart_out
);
  localparam logic [IW-1:0] RESTART_STEP = IW'(CORE_WORDS);
  localparam logic [IW-1:0] LAST_STEP = IW'(CORE_WORDS + 1);

  typedef struct packed {
    logic busy;
    logic load;
    logic we;
    logic req;
    logic done;
    logic [IW-1:0] step;
    logic [31:0] addr;
    logic [63:0] wdata;
    logic rvalid;
    logic [IW-1:0] ridx;
    logic [63:0] rword;
    logic [7:0] io_b;
    logic [7:0] halt_b;
    logic [31:0] rbase;
  } cmode_xfer_state_type;

  cmode_xfer_state_type s;
  cmode_xfer_state_type next_s;

  // Core words, then restart bytes, then base image; the fault address register is not among them
  function automatic logic [31:0] slot_addr(input logic [31:0] base, input logic [IW-1:0] step);
    if (step < RESTART_STEP) begin
      slot_addr = base + CM_SAVE_OFS + (32'(step) << CM_WORD_SHIFT);
    end else if (step == RESTART_STEP) begin
      slot_addr = base + CM_RESTART_OFS;
    end else begin
      slot_addr = base + CM_BASE_IMG_OFS;
    end
  endfunction : slot_addr

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.rvalid = 1'b0;
    if (!s.busy) begin
      if (ctl.start_save || ctl.start_restore) begin
        next_s.busy = 1'b1;
        next_s.load = 1'b1;
        next_s.we = ctl.start_save;
        next_s.step = '0;
        next_s.addr = slot_addr(ctl.base, '0);
      end
    end else if (s.load) begin
      next_s.load = 1'b0;
      next_s.req = 1'b1;
      if (s.step < RESTART_STEP) begin
        next_s.wdata = state_word_in;
      end else if (s.step == RESTART_STEP) begin
        next_s.wdata = {48'h0000_0000_0000, halt_restart_in, io_restart_in};
      end else begin
        next_s.wdata = {32'h0000_0000, ctl.base};
      end
    end else if (mem_ack_in) begin
      next_s.req = 1'b0;
      if (!s.we) begin
        if (s.step < RESTART_STEP) begin
          next_s.rvalid = 1'b1;
          next_s.ridx = s.step;
          next_s.rword = mem_rdata_in;
        end else if (s.step == RESTART_STEP) begin
          next_s.io_b = mem_rdata_in[CM_IO_BYTE_POS +: 8];
          next_s.halt_b = mem_rdata_in[CM_HALT_BYTE_POS +: 8];
        end else begin
          next_s.rbase = mem_rdata_in[31:0];
        end
      end
      if (s.step == LAST_STEP) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end else begin
        next_s.step = IW'(s.step + 1'b1);
        next_s.load = 1'b1;
        next_s.addr = slot_addr(ctl.base, IW'(s.step + 1'b1));
      end
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign state_idx_out = s.step;
  assign mem_req_out = s.req;
  assign mem_we_out = s.we;
  assign mem_addr_out = s.addr;
  assign mem_wdata_out = s.wdata;
  assign restore_valid_out = s.rvalid;
  assign restore_idx_out = s.ridx;
  assign restore_word_out = s.rword;
  assign io_restart_out = s.io_b;
  assign halt_restart_out = s.halt_b;
  assign ctl.done = s.done;
  assign ctl.restored_base = s.rbase;

  save_area_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    mem_req_out |-> (mem_addr_out >= ctl.base + CM_SAVE_OFS) && (mem_addr_out <= ctl.base + CM_SAVE_LAST_OFS))
    else $error("save-area access outside top 512 bytes");

  restart_byte_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (mem_req_out && mem_we_out && state_idx_out == RESTART_STEP) |-> (mem_wdata_out[63:16] == '0))
    else $error("restart entries wider than one byte");
endmodule : cmode_xfer

// >>> cmode_unit.sv
// Notes on behaviour
// - Entry writes processor state into control memory
// - Ordinary interrupts blocked from entry onward
// - Resume restores saved state and leaves mode
// - No translation, real addressing, 4G physical reach
// - Base register resets to 30000h
// - Default window 64K at 30000h, sizable
// - State saved at base plus 0FE00h
// - Handler fetched at base plus 8000h
// - Base changes only via edited saved image
// - Relocated base persists until change or reset
// - Revision identifier bit 17 always set
// - 16-bit defaults, selector shifted four bits
// - Without override, highest address is 10FFEFh
// - Code selector loaded 3000h at default base
// - Restart entries are one byte each
// - Fault address register never saved or restored
// - No external cache flush input pin
module cmode_unit
  import cmode_pkg::*;
#(
  parameter int CORE_WORDS = CM_CORE_WORDS_DEF,
  parameter logic [31:0] MEM_SIZE = CM_MEM_SIZE_DEF,
  localparam int IW = $clog2(CORE_WORDS + 2)
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic cmi_req_in,
  input wire logic resume_in,
  output logic [IW-1:0] state_idx_out,
  input wire logic [63:0] state_word_in,
  input wire logic [7:0] io_restart_in,
  input wire logic [7:0] halt_restart_in,
  output logic mem_req_out,
  output logic mem_we_out,
  output logic [31:0] mem_addr_out,
  output logic [63:0] mem_wdata_out,
  input wire logic mem_ack_in,
  input wire logic [63:0] mem_rdata_in,
  output logic restore_valid_out,
  output logic [IW-1:0] restore_idx_out,
  output logic [63:0] restore_word_out,
  output logic [7:0] io_restart_out,
  output logic [7:0] halt_restart_out,
  input wire logic [15:0] agu_sel_in,
  input wire logic [31:0] agu_off_in,
  input wire logic agu_override_in,
  output logic [31:0] agu_addr_out,
  output logic mode_active_out,
  output logic intr_block_out,
  output logic xlate_off_out,
  output logic opsize16_out,
  output logic fetch_start_out,
  output logic [31:0] fetch_addr_out,
  output logic [15:0] cs_sel_out,
  output logic [31:0] cs_base_out,
  output logic [31:0] base_out,
  output logic [31:0] window_last_out,
  output logic [31:0] revision_id_out,
  output logic resume_done_out
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic sync3;
    logic pending;
    cmode_phase_type phase;
    logic in_mode;
    logic start_save;
    logic start_restore;
    logic fetch_start;
    logic [31:0] fetch_addr;
    logic [15:0] cs_sel;
    logic [31:0] cs_base;
    logic [31:0] base;
    logic [31:0] wlast;
    logic [31:0] rev;
    logic resume_done;
  } cmode_top_state_type;

  localparam cmode_top_state_type TOP_RESET = '{
    phase: CM_IDLE,
    cs_sel: CM_CS_SEL_DEF,
    cs_base: CM_BASE_RESET,
    base: CM_BASE_RESET,
    wlast: CM_BASE_RESET + MEM_SIZE - 32'h0000_0001,
    rev: CM_REV_ID,
    default: '0
  };

  cmode_top_state_type s;
  cmode_top_state_type next_s;
  logic cmi_edge;

  cmode_seq_if seq_bus();
  cmode_agu_if agu_bus();

  assign cmi_edge = s.sync2 && !s.sync3;

  always_comb begin
    next_s = s;
    next_s.start_save = 1'b0;
    next_s.start_restore = 1'b0;
    next_s.fetch_start = 1'b0;
    next_s.resume_done = 1'b0;
    next_s.sync1 = cmi_req_in;
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    // A request during the mode is held, never lost
    next_s.pending = s.pending || cmi_edge;
    next_s.wlast = s.base + MEM_SIZE - 32'h0000_0001;
    case (s.phase)
      CM_IDLE: begin
        if (s.pending || cmi_edge) begin
          next_s.pending = 1'b0;
          next_s.phase = CM_SAVE;
          next_s.in_mode = 1'b1;
          next_s.start_save = 1'b1;
          next_s.cs_sel = s.base[19:4];
          next_s.cs_base = s.base;
        end
      end
      CM_SAVE: begin
        if (seq_bus.done) begin
          next_s.phase = CM_RUN;
          next_s.fetch_start = 1'b1;
          next_s.fetch_addr = s.base + CM_HANDLER_OFS;
        end
      end
      CM_RUN: begin
        if (resume_in) begin
          next_s.phase = CM_RESTORE;
          next_s.start_restore = 1'b1;
        end
      end
      CM_RESTORE: begin
        if (seq_bus.done) begin
          next_s.base = seq_bus.restored_base;
          next_s.phase = CM_IDLE;
          next_s.in_mode = 1'b0;
          next_s.resume_done = 1'b1;
        end
      end
      default: begin
        next_s.phase = CM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s <= TOP_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign seq_bus.start_save = s.start_save;
  assign seq_bus.start_restore = s.start_restore;
  assign seq_bus.base = s.base;

  // Save/restore walker; the memory port is the only path to control memory, no flush input exists
  cmode_xfer #(
    .CORE_WORDS(CORE_WORDS)
  ) u_xfer (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .ctl(seq_bus.seq),
    .state_idx_out(state_idx_out),
    .state_word_in(state_word_in),
    .io_restart_in(io_restart_in),
    .halt_restart_in(halt_restart_in),
    .mem_req_out(mem_req_out),
    .mem_we_out(mem_we_out),
    .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out),
    .mem_ack_in(mem_ack_in),
    .mem_rdata_in(mem_rdata_in),
    .restore_valid_out(restore_valid_out),
    .restore_idx_out(restore_idx_out),
    .restore_word_out(restore_word_out),
    .io_restart_out(io_restart_out),
    .halt_restart_out(halt_restart_out)
  );

  assign agu_bus.sel = agu_sel_in;
  assign agu_bus.off = agu_off_in;
  assign agu_bus.ovr = agu_override_in;

  cmode_agu u_agu (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .port(agu_bus.agu)
  );

  assign agu_addr_out = agu_bus.addr;
  assign mode_active_out = s.in_mode;
  assign intr_block_out = s.in_mode;
  assign xlate_off_out = s.in_mode;
  assign opsize16_out = s.in_mode;
  assign fetch_start_out = s.fetch_start;
  assign fetch_addr_out = s.fetch_addr;
  assign cs_sel_out = s.cs_sel;
  assign cs_base_out = s.cs_base;
  assign base_out = s.base;
  assign window_last_out = s.wlast;
  assign revision_id_out = s.rev;
  assign resume_done_out = s.resume_done;

  sequence accept_s;
    s.phase == CM_IDLE && (s.pending || cmi_edge);
  endsequence

  sequence entered_s;
    mode_active_out && intr_block_out && seq_bus.start_save;
  endsequence

  sequence exit_s;
    resume_done_out && !mode_active_out && !intr_block_out;
  endsequence

  entry_save_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    accept_s |=> entered_s)
    else $error("entry did not start the state save");

  block_hold_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (s.phase != CM_IDLE) |-> intr_block_out && xlate_off_out && opsize16_out)
    else $error("interrupts not blocked inside the mode");

  resume_exit_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (s.phase == CM_RESTORE && seq_bus.done) |=> exit_s ##1 !resume_done_out)
    else $error("resume did not leave the mode");

  resume_start_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (s.phase == CM_RUN && resume_in) |=> seq_bus.start_restore && mode_active_out)
    else $error("resume did not start the restore");

  handler_addr_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    fetch_start_out |-> (fetch_addr_out == base_out + CM_HANDLER_OFS) && mode_active_out)
    else $error("handler fetch address wrong");

  base_move_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $changed(base_out) |-> resume_done_out && (base_out == $past(seq_bus.restored_base)))
    else $error("base changed outside a resume");

  rev_bit_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    revision_id_out[CM_RELOC_BIT] && $stable(revision_id_out))
    else $error("relocation bit not reported");

  cs_load_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $rose(mode_active_out) |-> (cs_sel_out == base_out[19:4]) && (cs_base_out == base_out))
    else $error("code selector not loaded from base on entry");

  window_last_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $stable(base_out) |-> window_last_out == base_out + MEM_SIZE - 32'h0000_0001)
    else $error("control window bound wrong");

  sequence save_req_s;
    mem_req_out && mem_we_out && (mem_addr_out == base_out + CM_SAVE_OFS);
  endsequence

  sequence restore_req_s;
    mem_req_out && !mem_we_out && (mem_addr_out == base_out + CM_SAVE_OFS);
  endsequence

  pend_keep_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (s.phase != CM_IDLE && cmi_edge) |=> s.pending)
    else $error("request inside the mode was lost");

  pend_take_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (s.phase == CM_IDLE && s.pending) |=> mode_active_out && !s.pending)
    else $error("held request not taken after exit");

  exit_only_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $fell(mode_active_out) |-> resume_done_out)
    else $error("mode indication dropped before resume end");

  fetch_pulse_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    fetch_start_out |-> (s.phase == CM_RUN) ##1 !fetch_start_out)
    else $error("handler fetch start not a single pulse");

  base_keep_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (s.phase != CM_RESTORE) |=> $stable(base_out))
    else $error("base moved outside the restore");

  cs_default_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    ($rose(mode_active_out) && base_out == CM_BASE_RESET) |-> (cs_sel_out == CM_CS_SEL_DEF) && (cs_base_out == CM_BASE_RESET))
    else $error("default code selector wrong on entry");

  save_first_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    seq_bus.start_save |-> ##2 save_req_s)
    else $error("first save write missing or misplaced");

  restore_first_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    seq_bus.start_restore |-> ##2 restore_req_s)
    else $error("first restore read missing or misplaced");

  mode_req_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    mem_req_out |-> mode_active_out)
    else $error("control memory access outside the mode");
endmodule : cmode_unit

// >>> cmode_mem_model.sv
module cmode_mem_model (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic mem_req_in,
  input wire logic mem_we_in,
  input wire logic [31:0] mem_addr_in,
  input wire logic [63:0] mem_wdata_in,
  input wire logic [1:0] slow_in,
  output logic mem_ack_out,
  output logic [63:0] mem_rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] mem [logic [31:0]];
  logic [1:0] wait_cnt;

  // Every control memory address answers, at a selectable delay
  always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mem_ack_out <= 1'b0;
      mem_rdata_out <= '1;
      wait_cnt <= 2'd0;
    end else if (mem_req_in && !mem_ack_out && wait_cnt == slow_in) begin
      mem_ack_out <= #1 1'b1;
      wait_cnt <= 2'd0;
      if (mem_we_in) begin
        mem[mem_addr_in] = mem_wdata_in;
      end else begin
        mem_rdata_out <= #1 mem.exists(mem_addr_in) ? mem[mem_addr_in] : ~mem_rdata_out;
      end
    end else begin
      // Released data lines show a changing pattern
      mem_ack_out <= #1 1'b0;
      mem_rdata_out <= #1 ~mem_rdata_out;
      if (mem_req_in && !mem_ack_out) begin
        wait_cnt <= wait_cnt + 2'd1;
      end
    end
  end
endmodule : cmode_mem_model

// >>> testbench.sv
module testbench import cmode_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CW = 8;
  localparam logic [31:0] NEW_BASE = 32'h0010_0000;
  logic clock_in, rstn_in, cmi_req_in, resume_in, mem_req_out, mem_we_out, mem_ack_in, restore_valid_out;
  logic [3:0] state_idx_out, restore_idx_out;
  logic [63:0] state_word_in, mem_wdata_out, mem_rdata_in, restore_word_out;
  logic [7:0] io_restart_in, halt_restart_in, io_restart_out, halt_restart_out, io_s, halt_s;
  logic [31:0] mem_addr_out, agu_off_in, agu_addr_out, fetch_addr_out, cs_base_out, base_out;
  logic [31:0] window_last_out, revision_id_out, exp_a;
  logic [15:0] agu_sel_in, cs_sel_out;
  logic agu_override_in, mode_active_out, intr_block_out, xlate_off_out, opsize16_out;
  logic fetch_start_out, resume_done_out;
  logic [1:0] slow;
  logic [63:0] core_words [CW];
  logic [31:0] exp_wa [$];
  logic [63:0] exp_wd [$];
  logic [63:0] exp_rw [$];
  logic [3:0] exp_ri [$];
  int fail_count = 0;
  int tests_run = 0;

  assign state_word_in = (int'(state_idx_out) < CW) ? core_words[state_idx_out] : 64'h0;

  cmode_unit #(.CORE_WORDS(CW), .MEM_SIZE(CM_MEM_SIZE_DEF)) u_cmode_unit (
    .clock_in, .rstn_in, .cmi_req_in, .resume_in, .state_idx_out, .state_word_in, .io_restart_in,
    .halt_restart_in, .mem_req_out, .mem_we_out, .mem_addr_out, .mem_wdata_out, .mem_ack_in, .mem_rdata_in,
    .restore_valid_out, .restore_idx_out, .restore_word_out, .io_restart_out, .halt_restart_out, .agu_sel_in,
    .agu_off_in, .agu_override_in, .agu_addr_out, .mode_active_out, .intr_block_out, .xlate_off_out,
    .opsize16_out, .fetch_start_out, .fetch_addr_out, .cs_sel_out, .cs_base_out, .base_out, .window_last_out,
    .revision_id_out, .resume_done_out);

  cmode_mem_model u_cmode_mem_model (.clock_in, .rstn_in, .mem_req_in(mem_req_out), .mem_we_in(mem_we_out),
    .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out), .slow_in(slow), .mem_ack_out(mem_ack_in),
    .mem_rdata_out(mem_rdata_in));

  always #25 clock_in = ~clock_in;

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  task automatic wait_for(input int which);
    int n;
    for (n = 0; n < 400; n++) begin
      @(posedge clock_in);
      #1;
      if ((which == 0 ? fetch_start_out : resume_done_out) === 1'b1) begin
        return;
      end
    end
    check("wait bound", 1'b0, 1'b1);
    end_sim();
  endtask : wait_for

  task automatic fill_state();
    foreach (core_words[i]) begin
      core_words[i] = {$urandom(), $urandom()};
    end
    io_restart_in = 8'($urandom());
    halt_restart_in = 8'($urandom());
    slow = 2'($urandom());
  endtask : fill_state

  task automatic expect_save(input logic [31:0] b);
    for (int i = 0; i < CW; i++) begin
      exp_wa.push_back(b + CM_SAVE_OFS + 32'(8 * i));
      exp_wd.push_back(core_words[i]);
    end
    exp_wa.push_back(b + CM_RESTART_OFS);
    exp_wd.push_back({48'h0, halt_restart_in, io_restart_in});
    exp_wa.push_back(b + CM_BASE_IMG_OFS);
    exp_wd.push_back({32'h0, b});
  endtask : expect_save

  // Notes what the next restore must bring back from the last save
  task automatic note_restore();
    for (int i = 0; i < CW; i++) begin
      exp_ri.push_back(4'(i));
      exp_rw.push_back(core_words[i]);
    end
    io_s = io_restart_in;
    halt_s = halt_restart_in;
  endtask : note_restore

  task automatic resume(input logic [31:0] b);
    resume_in = 1'b1;
    @(posedge clock_in);
    #1;
    resume_in = 1'b0;
    wait_for(1);
    check("base", base_out, b);
    check("restart bytes", {halt_restart_out, io_restart_out}, {halt_s, io_s});
    check("restore left", exp_ri.size(), 0);
  endtask : resume

  task automatic entered(input logic [31:0] b);
    wait_for(0);
    check("fetch addr", fetch_addr_out, b + CM_HANDLER_OFS);
    check("cs", {cs_sel_out, cs_base_out}, {b[19:4], b});
    check("saves left", exp_wa.size(), 0);
  endtask : entered

  // Scoreboard: oldest note against each save write and each restored word
  always @(posedge clock_in) begin
    if (mem_req_out === 1'b1) begin
      check("active in transfer", mode_active_out, 1'b1);
    end
    if (mode_active_out === 1'b1) begin
      check("mode flags", {intr_block_out, xlate_off_out, opsize16_out}, 3'b111);
    end
    if (mem_req_out === 1'b1 && mem_ack_in === 1'b1 && mem_we_out === 1'b1) begin
      if (exp_wa.size() == 0) begin
        check("spare save", 1'b1, 1'b0);
      end else begin
        check("save addr", mem_addr_out, exp_wa.pop_front());
        check("save data", mem_wdata_out, exp_wd.pop_front());
      end
    end
    if (restore_valid_out === 1'b1) begin
      if (exp_ri.size() == 0) begin
        check("spare restore", 1'b1, 1'b0);
      end else begin
        check("restore idx", restore_idx_out, exp_ri.pop_front());
        check("restore word", restore_word_out, exp_rw.pop_front());
      end
    end
  end

  initial begin
    clock_in = 1'b0;
    rstn_in = 1'b0;
    {cmi_req_in, resume_in, agu_override_in, slow} = '0;
    {agu_sel_in, agu_off_in, io_restart_in, halt_restart_in} = '0;
    void'($urandom(32'h4b50_455c));
    fill_state();
    repeat (16) @(posedge clock_in);
    #1;
    rstn_in = 1'b1;
    check("reset base", base_out, 32'h0003_0000);
    check("reset window", window_last_out, 32'h0003_FFFF);
    check("reloc bit", revision_id_out[17], 1'b1);
    check("reset cs", {cs_sel_out, cs_base_out}, {16'h3000, 32'h0003_0000});
    check("reset idle", mode_active_out, 1'b0);
    expect_save(CM_BASE_RESET);
    cmi_req_in = 1'b1;
    entered(CM_BASE_RESET);
    cmi_req_in = 1'b0;
    repeat (4) @(posedge clock_in);
    #1;
    // Second request while in mode stays pending until exit
    cmi_req_in = 1'b1;
    repeat (4) @(posedge clock_in);
    #1;
    cmi_req_in = 1'b0;
    // Handler relocates base through the saved image
    u_cmode_mem_model.mem[CM_BASE_RESET + CM_BASE_IMG_OFS] = {32'h0, NEW_BASE};
    note_restore();
    fill_state();
    expect_save(NEW_BASE);
    resume(NEW_BASE);
    @(posedge clock_in);
    #1;
    check("window", window_last_out, NEW_BASE + CM_MEM_SIZE_DEF - 32'h1);
    entered(NEW_BASE);
    note_restore();
    resume(NEW_BASE);
    check("left mode", mode_active_out, 1'b0);
    for (int k = 0; k < 9; k++) begin
      agu_sel_in = (k == 0) ? 16'hFFFF : 16'($urandom());
      agu_off_in = (k == 0) ? 32'h0000_FFFF : $urandom();
      agu_override_in = (k == 0) ? 1'b0 : 1'($urandom());
      exp_a = {12'h0, agu_sel_in, 4'h0} + (agu_override_in ? agu_off_in : {16'h0, agu_off_in[15:0]});
      @(posedge clock_in);
      #1;
      check("agu addr", agu_addr_out, exp_a);
      if (k == 0) begin
        check("real max", agu_addr_out, 32'h0010_FFEF);
      end
    end
    rstn_in = 1'b0;
    repeat (2) @(posedge clock_in);
    #1;
    rstn_in = 1'b1;
    check("base after reset", base_out, CM_BASE_RESET);
    end_sim();
  end
endmodule : testbench
